// *** hdl/cwg_gate.sv ***
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "cwg_cfg.svh"

module cwg_gate
   import cwg_pkg::*;
#(
   parameter int BOOT_CYCLES = `CWG_BOOT_CYCLES,
   parameter int SEC_CYCLES  = `CWG_SEC_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire cwg_byte_t   rxByte,
   input  wire logic        rxValid,
   output logic             rxReady,
   output logic             rtsN,
   input  wire logic        ctsN,
   output logic      [7:0]  dataOut,
   output logic             dataOutValid,
   input  wire logic        dataOutReady,
   output logic      [7:0]  cmdByte,
   output logic             cmdValid,
   output logic             cmdMode,
   input  wire logic        connected,
   output logic             dropConn,
   input  wire logic [15:0] nvPower,
   output logic      [15:0] txPower,
   output logic      [15:0] nvPowerWr,
   output logic             nvPowerWrEn,
   output logic      [11:0] gpioOut,
   output logic      [11:0] gpioOeN
);

   // ==========================================================
   // Declarations
   logic [3:0]  ctrl_reg;
   logic [7:0]  cfgTimer_reg;
   logic [15:0] txSet_reg;
   logic [15:0] txUse_reg;
   logic        txLoad_reg;
   logic [11:0] gpioDir_reg;
   logic [11:0] gpioOut_reg;
   logic        nvWrEn_reg;
   logic        wrPend_reg;
   logic [7:0]  wrAddr_reg;
   logic [31:0] rdData_reg;
   logic [26:0] secCnt_reg;
   logic [26:0] bootCnt_reg;
   logic        bootReady_reg;
   logic [7:0]  upSecs_reg;
   logic [7:0]  idleSecs_reg;
   logic        drop_reg;
   logic        cmdMode_reg;
   cwg_esc_t    esc_reg;
   cwg_esc_t    esc_next;
   logic [7:0]  outData_reg;
   logic        outValid_reg;
   logic [7:0]  cmdByte_reg;
   logic        cmdValid_reg;

   cwg_byte_t   fifoOut;
   wire         fifoOutValid;
   wire         fifoFull;
   wire         fifoPop;
   wire         outTaken;
   wire         addrPhase;
   wire         rdPhase;
   wire [7:0]   rdAddr;
   wire         wrCtrl;
   wire         wrTimer;
   wire         wrTxSet;
   wire         wrGpioDir;
   wire         wrGpioOut;
   wire         wrCmd;
   wire         timerArgOk;
   wire         secTick;
   wire         forcedZero;
   wire [7:0]   effTimer;
   wire         timed;
   wire         inWindow;
   wire         localOpen;
   wire         remoteOpen;
   wire         scanOpen;
   wire         isEsc;
   wire         idleArmed;
   wire [15:0]  txPick;
   wire [31:0]  statusWord;
   wire [31:0]  rdMux;

   // ==========================================================
   // Host byte buffer; request-to-send stays low while it has room
   cwg_fifo
   #(
      .WIDTH ($bits(cwg_byte_t)),
      .DEPTH (`CWG_FIFO_DEPTH)
   )
   u_fifo
   (
      .clk      (clk),
      .reset_n  (reset_n),
      .inData   (rxByte),
      .inValid  (rxValid),
      .inReady  (rxReady),
      .outData  (fifoOut),
      .outValid (fifoOutValid),
      .outReady (fifoPop),
      .full     (fifoFull)
   );

   assign rtsN = fifoFull;

   // ==========================================================
   // Bus decode
   assign addrPhase = hsel && htrans[1] && hready;
   assign rdPhase   = addrPhase && !hwrite;
   assign rdAddr    = haddr[7:0];
   assign wrCtrl    = wrPend_reg && (wrAddr_reg == `CWG_OFF_CTRL);
   assign wrTimer   = wrPend_reg && (wrAddr_reg == `CWG_OFF_CFG_TIMER);
   assign wrTxSet   = wrPend_reg && (wrAddr_reg == `CWG_OFF_TXPWR_SET);
   assign wrGpioDir = wrPend_reg && (wrAddr_reg == `CWG_OFF_GPIO_DIR);
   assign wrGpioOut = wrPend_reg && (wrAddr_reg == `CWG_OFF_GPIO_OUT);
   assign wrCmd     = wrPend_reg && (wrAddr_reg == `CWG_OFF_CMD);
   assign timerArgOk = (hwdata[31:8] == 24'h000000);

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdData_reg;

   assign statusWord = {16'h0000, upSecs_reg, 1'b0, drop_reg, fifoFull, connected,
                        remoteOpen, localOpen, bootReady_reg, cmdMode_reg};

   // Query shows the power in use, not the stored request
   assign rdMux =
      (rdAddr == `CWG_OFF_CTRL)      ? {28'h0000000, ctrl_reg} :
      (rdAddr == `CWG_OFF_CFG_TIMER) ? {24'h000000, cfgTimer_reg} :
      (rdAddr == `CWG_OFF_TXPWR_SET) ? {16'h0000, txSet_reg} :
      (rdAddr == `CWG_OFF_TXPWR_USE) ? {16'h0000, txUse_reg} :
      (rdAddr == `CWG_OFF_GPIO_DIR)  ? {20'h00000, gpioDir_reg} :
      (rdAddr == `CWG_OFF_GPIO_OUT)  ? {20'h00000, gpioOut_reg} :
      (rdAddr == `CWG_OFF_STATUS)    ? statusWord :
      32'h0000_0000;

   // Read data is caught in the address phase, so the slave needs no wait state
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
         rdData_reg <= 32'h0000_0000;
      end
      else
      begin
         wrPend_reg <= addrPhase && hwrite;
         if (addrPhase)
            wrAddr_reg <= haddr[7:0];
         if (rdPhase)
            rdData_reg <= rdMux;
      end
   end

   // ==========================================================
   // Software registers
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         ctrl_reg     <= `CWG_RST_CTRL;
         cfgTimer_reg <= `CWG_RST_CFG_TIMER;
         txSet_reg    <= `CWG_RST_TXPWR;
         nvWrEn_reg   <= 1'b0;
      end
      else
      begin
         nvWrEn_reg <= wrTxSet;
         if (wrCtrl)
            ctrl_reg <= hwdata[3:0];
         if (wrTimer && timerArgOk)
            cfgTimer_reg <= hwdata[7:0];
         if (wrTxSet)
            txSet_reg <= hwdata[15:0];
      end
   end

   assign nvPowerWr   = txSet_reg;
   assign nvPowerWrEn = nvWrEn_reg;

   // ==========================================================
   // GPIO direction; a low enable drives the pin
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         gpioDir_reg <= `CWG_RST_GPIO_DIR;
         gpioOut_reg <= `CWG_RST_GPIO_OUT;
      end
      else
      begin
         if (wrGpioDir && (hwdata == `CWG_GPIO_ALL_IN_ARG))
            gpioDir_reg <= `CWG_GPIO_ALL_IN;
         else if (wrGpioDir)
            gpioDir_reg <= hwdata[11:0];
         if (wrGpioOut)
            gpioOut_reg <= hwdata[11:0];
      end
   end

   assign gpioOeN = gpioDir_reg;
   assign gpioOut = gpioOut_reg;

   // ==========================================================
   // Power in use: stored value picked up once after reset release
   function automatic logic [15:0] pick_power(input logic [15:0] s);
      logic [15:0] r;
      r = s;
      if (s == `CWG_PWR_ZERO)
         r = `CWG_PWR_ZERO;
      else if ($signed(s) > $signed(`CWG_PWR_MAX))
         r = `CWG_PWR_MAX;
      else if ($signed(s) < $signed(`CWG_PWR_MIN))
         r = `CWG_PWR_MIN;
      else
         r = {s[15:2], 2'b00};
      return r;
   endfunction

   assign txPick = pick_power(nvPower);

   // Loading only at reset release keeps a new setting from acting early
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         txLoad_reg <= 1'b1;
         txUse_reg  <= `CWG_RST_TXPWR;
      end
      else
      begin
         txLoad_reg <= 1'b0;
         if (txLoad_reg)
            txUse_reg <= txPick;
      end
   end

   assign txPower = txUse_reg;

   // ==========================================================
   // Boot delay and seconds since start
   assign secTick = (secCnt_reg == 27'(SEC_CYCLES - 1));

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         secCnt_reg    <= 27'h0000000;
         bootCnt_reg   <= 27'h0000000;
         bootReady_reg <= 1'b0;
         upSecs_reg    <= 8'h00;
      end
      else
      begin
         secCnt_reg <= secTick ? 27'h0000000 : secCnt_reg + 27'h0000001;
         if (!bootReady_reg)
            bootCnt_reg <= bootCnt_reg + 27'h0000001;
         if (bootCnt_reg == 27'(BOOT_CYCLES - 1))
            bootReady_reg <= 1'b1;
         if (secTick && (upSecs_reg != 8'hff))
            upSecs_reg <= upSecs_reg + 8'h01;
      end
   end

   // ==========================================================
   // Configuration window
   assign forcedZero = ctrl_reg[`CWG_CTRL_MASTER] || ctrl_reg[`CWG_CTRL_AUTOCONN] ||
                       ctrl_reg[`CWG_CTRL_TRIGGER];
   assign effTimer   = forcedZero ? `CWG_TMR_OFF : cfgTimer_reg;
   assign timed      = (effTimer != `CWG_TMR_OFF) && (effTimer <= `CWG_TMR_MAX_TIMED);
   assign inWindow   = (upSecs_reg < effTimer);

   assign localOpen =
      (effTimer == `CWG_TMR_OFF) ? !connected :
      timed ? inWindow :
      (effTimer == `CWG_TMR_LOCAL) || (effTimer == `CWG_TMR_BOTH);

   assign remoteOpen =
      timed ? inWindow :
      (effTimer == `CWG_TMR_REMOTE) || (effTimer == `CWG_TMR_BOTH);

   // Closed window means the byte is only forwarded, never inspected
   assign scanOpen = bootReady_reg &&
                     (fifoOut.remote ? remoteOpen : localOpen);

   // ==========================================================
   // Trigger master idle timer
   assign idleArmed = ctrl_reg[`CWG_CTRL_TRIGGER] && connected &&
                      (cfgTimer_reg != `CWG_TMR_OFF) &&
                      (cfgTimer_reg <= `CWG_TMR_MAX_TIMED);

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         idleSecs_reg <= 8'h00;
         drop_reg     <= 1'b0;
      end
      else
      begin
         drop_reg <= 1'b0;
         if (!idleArmed || fifoPop)
            idleSecs_reg <= 8'h00;
         else if (secTick && (idleSecs_reg + 8'h01 == cfgTimer_reg))
         begin
            idleSecs_reg <= 8'h00;
            drop_reg     <= 1'b1;
         end
         else if (secTick)
            idleSecs_reg <= idleSecs_reg + 8'h01;
      end
   end

   assign dropConn = drop_reg;

   // ==========================================================
   // Drain: command bytes go to the interpreter, others out to the link
   assign outTaken = outValid_reg && dataOutReady && !ctsN;
   assign fifoPop  = fifoOutValid && (cmdMode_reg || !outValid_reg || outTaken);
   assign isEsc    = (fifoOut.data == `CWG_ESC_CHAR);

   always_comb
   begin
      esc_next = esc_reg;
      if (fifoPop && !cmdMode_reg)
      begin
         if (!scanOpen || !isEsc)
            esc_next = ESC_NONE;
         else
         begin
            case (esc_reg)
               ESC_NONE : esc_next = ESC_ONE;
               ESC_ONE  : esc_next = ESC_TWO;
               ESC_TWO  : esc_next = ESC_NONE;
               default  : esc_next = ESC_NONE;
            endcase
         end
      end
   end

   // Escape bytes are still forwarded: dropping them would need a lookahead buffer
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         esc_reg      <= ESC_NONE;
         cmdMode_reg  <= 1'b0;
         outValid_reg <= 1'b0;
         outData_reg  <= 8'h00;
         cmdValid_reg <= 1'b0;
         cmdByte_reg  <= 8'h00;
      end
      else
      begin
         esc_reg      <= esc_next;
         cmdValid_reg <= 1'b0;
         if (fifoPop && !cmdMode_reg && scanOpen && isEsc && (esc_reg == ESC_TWO))
            cmdMode_reg <= 1'b1;
         else if (wrCmd && hwdata[`CWG_CMD_EXIT])
            cmdMode_reg <= 1'b0;
         if (fifoPop && cmdMode_reg)
         begin
            cmdValid_reg <= 1'b1;
            cmdByte_reg  <= fifoOut.data;
         end
         if (fifoPop && !cmdMode_reg)
         begin
            outValid_reg <= 1'b1;
            outData_reg  <= fifoOut.data;
         end
         else if (outTaken)
            outValid_reg <= 1'b0;
      end
   end

   assign dataOut      = outData_reg;
   assign dataOutValid = outValid_reg && !ctsN;
   assign cmdByte      = cmdByte_reg;
   assign cmdValid     = cmdValid_reg;
   assign cmdMode      = cmdMode_reg;

endmodule

// *** pkg/cwg_cfg.svh ***
`ifndef CWG_CFG_SVH
`define CWG_CFG_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define CWG_OFF_CTRL        8'h00
`define CWG_OFF_CFG_TIMER   8'h04
`define CWG_OFF_TXPWR_SET   8'h08
`define CWG_OFF_TXPWR_USE   8'h0c
`define CWG_OFF_GPIO_DIR    8'h10
`define CWG_OFF_GPIO_OUT    8'h14
`define CWG_OFF_STATUS      8'h18
`define CWG_OFF_CMD         8'h1c

// ==========================================================
// Control field positions
`define CWG_CTRL_MASTER     0
`define CWG_CTRL_AUTOCONN   1
`define CWG_CTRL_TRIGGER    2
`define CWG_CTRL_HCI        3
`define CWG_CMD_EXIT        0

// ==========================================================
// Reset values and codes
`define CWG_RST_CTRL        4'h0
`define CWG_RST_CFG_TIMER   8'h3c
`define CWG_RST_TXPWR       16'h0010
`define CWG_RST_GPIO_DIR    12'h000
`define CWG_RST_GPIO_OUT    12'h000
`define CWG_GPIO_ALL_IN_ARG 32'h0000_1000
`define CWG_GPIO_ALL_IN     12'hfff
`define CWG_PWR_MAX         16'h0010
`define CWG_PWR_MIN         16'hfff4
`define CWG_PWR_ZERO        16'h0000
`define CWG_TMR_OFF         8'h00
`define CWG_TMR_MAX_TIMED   8'hfc
`define CWG_TMR_LOCAL       8'hfd
`define CWG_TMR_REMOTE      8'hfe
`define CWG_TMR_BOTH        8'hff
`define CWG_ESC_CHAR        8'h24

// ==========================================================
// Timing
`define CWG_CLK_HZ          125000000
`define CWG_BOOT_MS         500
`define CWG_BOOT_CYCLES     ((`CWG_BOOT_MS * (`CWG_CLK_HZ / 1000)))
`define CWG_SEC_CYCLES      (`CWG_CLK_HZ)
`define CWG_FIFO_DEPTH      32

`endif

// *** pkg/cwg_pkg.sv ***
package cwg_pkg;

   // ==========================================================
   // Byte on the host stream, tagged with its origin
   typedef struct packed
   {
      logic       remote;
      logic [7:0] data;
   } cwg_byte_t;

   // ==========================================================
   // Escape detector progress
   typedef enum logic [1:0]
   {
      ESC_NONE,
      ESC_ONE,
      ESC_TWO
   } cwg_esc_t;

endpackage

// *** hdl/cwg_fifo.sv ***
`timescale 1ns/1ps

module cwg_fifo
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
)
(
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic                  full
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_reg;
   logic [AW:0]      rdPtr_reg;
   wire              push;
   wire              pop;
   wire              empty;

   // ==========================================================
   // Extra pointer bit tells full from empty
   assign empty    = (wrPtr_reg == rdPtr_reg);
   assign full     = (wrPtr_reg[AW] != rdPtr_reg[AW]) &&
                     (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
   assign inReady  = !full;
   assign outValid = !empty;
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   assign outData  = mem[rdPtr_reg[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wrPtr_reg[AW-1:0]] <= inData;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
      end
      else
      begin
         wrPtr_reg <= wrPtr_reg + (AW+1)'(push);
         rdPtr_reg <= rdPtr_reg + (AW+1)'(pop);
      end
   end

endmodule

// *** tb/cwg_checker.sv ***
`timescale 1ns/1ps
`include "cwg_cfg.svh"

module cwg_checker
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        rxReady,
   input wire logic        rtsN,
   input wire logic        ctsN,
   input wire logic [7:0]  dataOut,
   input wire logic        dataOutValid,
   input wire logic        dataOutReady,
   input wire logic        connected,
   input wire logic        dropConn,
   input wire logic [15:0] txPower,
   input wire logic [15:0] nvPowerWr,
   input wire logic [11:0] gpioOeN
);
   logic take;
   logic wrGpio;
   logic wrPwr;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // ==========
   // Write data phases of interest
   assign take = hsel && htrans[1] && hready && hwrite;
   always_ff @(posedge clk)
   begin
      wrGpio <= reset_n && take && haddr[7:0] == `CWG_OFF_GPIO_DIR;
      wrPwr  <= reset_n && take && haddr[7:0] == `CWG_OFF_TXPWR_SET;
   end

   // ==========
   // Properties
   a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
      else $error("bus answer not zero-wait okay");
   a_cts_blocks: assert property (ctsN |-> !dataOutValid)
      else $error("byte offered while clear-to-send is high");
   a_rts_full: assert property (rtsN == !rxReady)
      else $error("request-to-send disagrees with receive ready");
   a_out_holds: assert property (dataOutValid && !dataOutReady
      |=> $stable(dataOut))
      else $error("offered byte changed before it was taken");
   a_drop_pulse: assert property (dropConn |=> !dropConn)
      else $error("drop request longer than one cycle");
   a_drop_link: assert property (dropConn |-> $past(connected))
      else $error("drop request without a link");
   a_gpio_all_in: assert property (wrGpio && hwdata == `CWG_GPIO_ALL_IN_ARG
      |=> gpioOeN == `CWG_GPIO_ALL_IN)
      else $error("pins not all made inputs");
   a_power_held: assert property ($past(reset_n) |=> $stable(txPower))
      else $error("power in use changed outside reset");
   a_power_table: assert property (txPower inside {16'h0010, 16'h000c, 16'h0008,
      16'h0004, 16'h0000, 16'hfffc, 16'hfff8, 16'hfff4})
      else $error("power in use not a table entry");
   a_power_store: assert property (wrPwr
      |=> {16'h0000, nvPowerWr} == ($past(hwdata) & 32'h0000ffff))
      else $error("stored power differs from written value");

   c_flow_full: cover property (rtsN);
   c_byte_out: cover property (dataOutValid && dataOutReady);
   c_drop: cover property (dropConn);
endmodule

bind cwg_gate cwg_checker u_checker
(
   .clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hreadyout, .hresp,
   .rxReady, .rtsN, .ctsN, .dataOut, .dataOutValid, .dataOutReady, .connected, .dropConn,
   .txPower, .nvPowerWr, .gpioOeN
);

// *** tb/cwg_host_model.sv ***
`timescale 1ns/1ps

module cwg_host_model
   import cwg_pkg::*;
(
   input  wire logic       clk,
   output cwg_byte_t       rxByte,
   output logic            rxValid,
   input  wire logic       rxReady,
   input  wire logic       rtsN,
   output logic            ctsN,
   input  wire logic [7:0] dataOut,
   input  wire logic       dataOutValid,
   output logic            dataOutReady,
   input  wire logic       ctsHold,
   input  wire logic       sinkStall
);
   cwg_byte_t  txQ[$];
   logic [7:0] gotQ[$];

   initial
   begin
      rxByte = '0;
      rxValid = 1'b0;
      ctsN = 1'b0;
      dataOutReady = 1'b1;
   end

   // ==========
   // Host UART side; a released data line is scrambled, not left at its last byte
   always @(posedge clk)
   begin
      if (dataOutValid && dataOutReady)
         gotQ.push_back(dataOut);
      ctsN <= ctsHold;
      dataOutReady <= !sinkStall;
      if (rxValid && rxReady)
         void'(txQ.pop_front());
      if (!rxValid || rxReady)
      begin
         rxValid <= txQ.size() > 0 && !rtsN;
         rxByte <= (txQ.size() > 0 && !rtsN) ? txQ[0] : ~rxByte;
      end
   end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "cwg_cfg.svh"

module tb
   import cwg_pkg::*;
;
   logic        clk = 1'b0, reset_n = 1'b0, hsel = 1'b1, hwrite = 1'b0;
   logic        connected = 1'b0, ctsHold = 1'b0, sinkStall = 1'b0;
   logic        hreadyout, hresp, rxValid, rxReady, rtsN, ctsN, dataOutValid;
   logic        dataOutReady, cmdValid, cmdMode, dropConn, nvPowerWrEn;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [7:0]  dataOut, cmdByte;
   logic [7:0]  cmdQ[$];
   logic [11:0] gpioOut, gpioOeN;
   logic [15:0] nvPower = 16'hfffa, txPower, nvPowerWr;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   cwg_byte_t   rxByte;
   int          failures = 0, checked = 0, n;

   localparam logic [39:0] regTab[6] = '{{`CWG_OFF_CTRL, 32'h0}, {`CWG_OFF_CFG_TIMER, 32'h3c},
      {`CWG_OFF_TXPWR_SET, 32'h10}, {`CWG_OFF_GPIO_DIR, 32'h0}, {`CWG_OFF_GPIO_OUT, 32'h0},
      {8'h20, 32'h0}};
   localparam logic [15:0] pwrTab[6] = '{16'h0000, 16'h0013, 16'h0010, 16'h0001, 16'hfff1,
      16'h0007};
   localparam logic [14:0] winTab[10] = '{{4'h0, 8'hc8, 3'h3}, {4'h0, 8'h02, 3'h0},
      {4'h0, 8'h00, 3'h1}, {4'h0, 8'h00, 3'h4}, {4'h0, 8'hfd, 3'h5}, {4'h0, 8'hfe, 3'h2},
      {4'h0, 8'hff, 3'h7}, {4'h1, 8'hff, 3'h1}, {4'h2, 8'hff, 3'h1}, {4'h4, 8'hff, 3'h4}};

   cwg_gate #(.BOOT_CYCLES(50), .SEC_CYCLES(100)) DUT
   (
      .clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .rxByte, .rxValid, .rxReady, .rtsN, .ctsN, .dataOut,
      .dataOutValid, .dataOutReady, .cmdByte, .cmdValid, .cmdMode, .connected, .dropConn,
      .nvPower, .txPower, .nvPowerWr, .nvPowerWrEn, .gpioOut, .gpioOeN
   );

   cwg_host_model host
   (
      .clk, .rxByte, .rxValid, .rxReady, .rtsN, .ctsN, .dataOut, .dataOutValid,
      .dataOutReady, .ctsHold, .sinkStall
   );

   always #4 clk = ~clk;

   always @(posedge clk)
      if (cmdValid === 1'b1)
         cmdQ.push_back(cmdByte);

   // ==========
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // The idle edge lets the write land before anything is compared
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      @(posedge clk);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(rd, e);
   endtask

   task automatic doReset(input logic [15:0] nv);
      reset_n <= 1'b0;
      nvPower <= nv;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      host.gotQ.delete();
      cmdQ.delete();
   endtask

   task automatic send(input string s, input logic rem);
      for (int i = 0; i < s.len(); i++)
         host.txQ.push_back(cwg_byte_t'({rem, s[i]}));
      for (int k = 0; k < 600 && (host.txQ.size() > 0 || rxValid); k++)
         @(posedge clk);
      repeat (6) @(posedge clk);
   endtask

   function automatic logic [15:0] pickPower(input logic [15:0] v);
      if (v == 16'h0000)
         return 16'h0000;
      if ($signed(v) > $signed(16'h0010))
         return 16'h0010;
      if ($signed(v) < $signed(16'hfff4))
         return 16'hfff4;
      return v & 16'hfffc;
   endfunction

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ==========
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("wrong value at %0t: watchdog expired", $time);
      conclude();
   end

   // ==========
   // Tests
   initial
   begin
      doReset(16'hfffa);
      send("$$$", 1'b0);
      check(cmdMode, 1'b0);
      bus(1'b0, `CWG_OFF_STATUS, 32'h0);
      check(rd[3:1], 3'h6);
      foreach (regTab[i])
         rdChk(regTab[i][39:32], regTab[i][31:0]);
      rdChk(`CWG_OFF_TXPWR_USE, {16'h0, pickPower(16'hfffa)});
      $display("reset values done");
      foreach (pwrTab[i])
      begin
         doReset(pwrTab[i]);
         check(txPower, pickPower(pwrTab[i]));
      end
      wr(`CWG_OFF_TXPWR_SET, 32'h0000fffc);
      check(nvPowerWrEn, 1'b1);
      check(nvPowerWr, 16'hfffc);
      check(txPower, 16'h0004);
      rdChk(`CWG_OFF_TXPWR_USE, 32'h00000004);
      wr(`CWG_OFF_GPIO_DIR, 32'h00000005);
      check(gpioOeN, 12'h005);
      wr(`CWG_OFF_GPIO_OUT, 32'h00000a5a);
      check(gpioOut, 12'ha5a);
      wr(`CWG_OFF_GPIO_DIR, 32'h00001000);
      check(gpioOeN, 12'hfff);
      doReset(nvPowerWr);
      check(txPower, 16'hfffc);
      $display("power and pins done");
      repeat (60) @(posedge clk);
      send("$$x$", 1'b0);
      check(cmdMode, 1'b0);
      send("$$", 1'b0);
      check(cmdMode, 1'b1);
      send("ok", 1'b0);
      check({cmdQ[0], cmdQ[1]}, 16'h6f6b);
      wr(`CWG_OFF_CMD, 32'h1);
      check(cmdMode, 1'b0);
      $display("escape done");
      repeat (300) @(posedge clk);
      foreach (winTab[i])
      begin
         wr(`CWG_OFF_CTRL, {28'h0, winTab[i][14:11]});
         wr(`CWG_OFF_CFG_TIMER, {24'h0, winTab[i][10:3]});
         connected <= winTab[i][2];
         @(posedge clk);
         bus(1'b0, `CWG_OFF_STATUS, 32'h0);
         check(rd[3:2], winTab[i][1:0]);
      end
      wr(`CWG_OFF_CFG_TIMER, 32'h100);
      rdChk(`CWG_OFF_CFG_TIMER, 32'hff);
      $display("window done");
      wr(`CWG_OFF_CTRL, 32'h0);
      wr(`CWG_OFF_CFG_TIMER, 32'h2);
      connected <= 1'b0;
      host.gotQ.delete();
      send("$$$", 1'b1);
      check(cmdMode, 1'b0);
      check({host.gotQ[0], host.gotQ[1], host.gotQ[2]}, 24'h242424);
      host.gotQ.delete();
      ctsHold <= 1'b1;
      sinkStall <= 1'b1;
      for (int i = 0; i < 40; i++)
         host.txQ.push_back(cwg_byte_t'({1'b0, 8'h40 + i[7:0]}));
      repeat (100) @(posedge clk);
      check(rtsN, 1'b1);
      check(host.gotQ.size(), 0);
      ctsHold <= 1'b0;
      repeat (20) @(posedge clk);
      sinkStall <= 1'b0;
      send("", 1'b0);
      // A full buffer still drains one byte a cycle after the host queue empties
      repeat (40) @(posedge clk);
      check(host.gotQ.size(), 40);
      for (int i = 0; i < 40; i++)
         check(host.gotQ[i], 8'h40 + i[7:0]);
      check(rtsN, 1'b0);
      $display("pass-through and flow done");
      wr(`CWG_OFF_CTRL, 32'h4);
      connected <= 1'b1;
      send("z", 1'b0);
      n = 0;
      while (n < 400 && dropConn !== 1'b1)
      begin
         @(posedge clk);
         n++;
      end
      check(n >= 50 && n < 400, 1'b1);
      $display("idle drop done");
      conclude();
   end
endmodule
